/* File: wdr_cfg.svh */
// constants of the watchdog and reset source unit
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH

// ==========================================================
// timing
`define WDR_CLK_PERIOD_PS  4000
`define WDR_TCL_PS         (`WDR_CLK_PERIOD_PS / 2)
`define WDR_FILTER_NS      50
`define WDR_FILTER_CYC     ((`WDR_FILTER_NS * 1000 + `WDR_CLK_PERIOD_PS - 1) / `WDR_CLK_PERIOD_PS)
`define WDR_SYNC_TCL       12
`define WDR_SYNC_CYC       ((`WDR_SYNC_TCL * `WDR_TCL_PS) / `WDR_CLK_PERIOD_PS)
`define WDR_SEQ_TCL        1024
`define WDR_SEQ_CYC        ((`WDR_SEQ_TCL * `WDR_TCL_PS) / `WDR_CLK_PERIOD_PS)
`define WDR_SAMPLE_TCL     8
`define WDR_SAMPLE_CYC     ((`WDR_SAMPLE_TCL * `WDR_TCL_PS) / `WDR_CLK_PERIOD_PS)
`define WDR_PRESC_LO       2
`define WDR_PRESC_HI       128

// ==========================================================
// register offsets (byte addresses)
`define WDR_OFS_CTRL       5'h00
`define WDR_OFS_RELOAD     5'h04
`define WDR_OFS_COUNT      5'h08
`define WDR_OFS_IRQ_STAT   5'h0C
`define WDR_OFS_IRQ_MASK   5'h10

// ==========================================================
// control register fields
`define WDR_CTRL_PRESC     0
`define WDR_CTRL_BIDIR     1
`define WDR_CTRL_ENABLED   2
`define WDR_CTRL_INITDONE  3
`define WDR_CTRL_FLAG_LSB  4
// flag vector positions
`define WDR_FLAG_PON       0
`define WDR_FLAG_SHORT     1
`define WDR_FLAG_LONG      2
`define WDR_FLAG_OVF       3
`define WDR_FLAG_SW        4
`define WDR_FLAGS_RESET    5'h01
// interrupt event positions
`define WDR_EV_OVF         0
`define WDR_EV_SW          1
`define WDR_EV_HW          2
`define WDR_EV_DIS_IGN     3

`endif

/* File: wdr_pkg.sv */
// types of the watchdog and reset source unit
package wdr_pkg;
   typedef enum logic [4:0] {
      WDR_IDLE   = 5'h01,
      WDR_ASYNC  = 5'h02,
      WDR_SYNC   = 5'h04,
      WDR_SEQ    = 5'h08,
      WDR_SAMPLE = 5'h10
   } wdr_state_t;

   typedef enum logic [1:0] {
      WDR_SRC_NONE = 2'h0,
      WDR_SRC_HW   = 2'h1,
      WDR_SRC_SW   = 2'h2,
      WDR_SRC_WD   = 2'h3
   } wdr_src_t;
endpackage

/* File: wdr_link_if.sv */
// internal link between the core, the prescaler and the pin filter
`timescale 1ns/100ps
interface wdr_link_if;
   logic presc_sel;
   logic presc_clr;
   logic presc_tick;
   logic pin_raw_n;
   logic filt_low;
   modport core_mp  (output presc_sel, presc_clr, pin_raw_n, input presc_tick, filt_low);
   modport presc_mp (input presc_sel, presc_clr, output presc_tick);
   modport filt_mp  (input pin_raw_n, output filt_low);
endinterface

/* File: wdr_prescaler.sv */
// counter clock prescaler, one-cycle tick every 2 or 128 clocks
`timescale 1ns/100ps
`include "wdr_cfg.svh"
module wdr_prescaler
   import wdr_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      reset_in,
   wdr_link_if.presc_mp   lnk
);
   localparam logic [6:0] LAST_LO = 7'(`WDR_PRESC_LO - 1);
   localparam logic [6:0] LAST_HI = 7'(`WDR_PRESC_HI - 1);

   logic [6:0] cnt_reg;
   logic [6:0] cnt_next;
   logic       tick_reg;
   logic       tick_next;
   logic [6:0] last;

   // ==========================================================
   // divider
   always_comb begin
      last      = lnk.presc_sel ? LAST_HI : LAST_LO;
      cnt_next  = cnt_reg + 7'h01;
      tick_next = 1'b0;
      if (lnk.presc_clr) begin
         cnt_next = 7'h00;
      end else if (cnt_reg >= last) begin
         cnt_next  = 7'h00;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_reg  <= 7'h00;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign lnk.presc_tick = tick_reg;
endmodule

/* File: wdr_pin_filter.sv */
// reset input pin synchroniser and glitch filter
`timescale 1ns/100ps
`include "wdr_cfg.svh"
module wdr_pin_filter
   import wdr_pkg::*;
#(
   parameter int FILT_CYC = `WDR_FILTER_CYC
)(
   input  wire logic      clk_in,
   input  wire logic      reset_in,
   wdr_link_if.filt_mp    lnk
);
   localparam logic [7:0] FILT_LAST = 8'(FILT_CYC - 1);

   logic       sync1_reg;
   logic       sync2_reg;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic       low_reg;
   logic       low_next;

   // ==========================================================
   // level must hold for the whole window before it is believed
   always_comb begin
      cnt_next = 8'h00;
      low_next = low_reg;
      if (!sync2_reg != low_reg) begin
         if (cnt_reg >= FILT_LAST) begin
            low_next = !sync2_reg;
         end else begin
            cnt_next = cnt_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         cnt_reg   <= 8'h00;
         low_reg   <= 1'b0;
      end else begin
         sync1_reg <= lnk.pin_raw_n;
         sync2_reg <= sync1_reg;
         cnt_reg   <= cnt_next;
         low_reg   <= low_next;
      end
   end

   assign lnk.filt_low = low_reg;
endmodule

/* File: wdr_top.sv */
// watchdog counter, reset sequencer and reset source flags with avalon-mm registers
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "wdr_cfg.svh"
module wdr_top
   import wdr_pkg::*;
#(
   parameter int CNT_W = 16
)(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic [4:0]  address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [31:0] writedata_in,
   input  wire logic [3:0]  byteenable_in,
   output logic      [31:0] readdata_out,
   output logic             waitrequest_out,
   input  wire logic        service_in,
   input  wire logic        disable_in,
   input  wire logic        end_of_init_in,
   input  wire logic        software_reset_in,
   input  wire logic        reset_in_pin_n_in,
   output logic             reset_in_pin_out,
   output logic             reset_in_pin_oe_out,
   input  wire logic        reset_mode_pin_in,
   output logic             reset_out_pin_n_out,
   output logic             chip_reset_out,
   output logic             irq_out
);
   localparam logic [9:0] SYNC_LAST   = 10'(`WDR_SYNC_CYC - 1);
   localparam logic [9:0] SEQ_LAST    = 10'(`WDR_SEQ_CYC - 1);
   localparam logic [9:0] SAMPLE_LAST = 10'(`WDR_SAMPLE_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   wdr_link_if lnk ();

   wdr_prescaler u_presc (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .lnk      (lnk.presc_mp)
   );

   wdr_pin_filter #(.FILT_CYC(`WDR_FILTER_CYC)) u_filt (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .lnk      (lnk.filt_mp)
   );

   // ==========================================================
   // state
   wdr_state_t       state_reg,   state_next;
   wdr_src_t         src_reg,     src_next;
   logic [9:0]       tmr_reg,     tmr_next;
   logic [CNT_W-1:0] count_reg,   count_next;
   logic [7:0]       reload_reg,  reload_next;
   logic             presc_reg,   presc_next;
   logic             bidir_reg,   bidir_next;
   logic             enabled_reg, enabled_next;
   logic             init_reg,    init_next;
   logic [4:0]       flags_reg,   flags_next;
   logic [3:0]       stat_reg,    stat_next;
   logic [3:0]       mask_reg,    mask_next;
   logic             oe_reg,      oe_next;
   logic             ack_reg,     ack_next;
   logic [31:0]      rdata_reg,   rdata_next;
   logic             mode_s1_reg;
   logic             mode_s2_reg;
   logic             idle;
   logic             counting;
   logic             svc_fire;
   logic             ovf_fire;
   logic             seq_done;
   logic             wr_fire;
   logic [3:0]       ev;
   logic [31:0]      ctrl_val;
   logic [31:0]      rd_val;

   assign idle     = (state_reg == WDR_IDLE);
   assign counting = idle && enabled_reg;
   assign svc_fire = idle && service_in;
   assign ovf_fire = counting && lnk.presc_tick && !svc_fire && (count_reg == CNT_MAX);
   assign seq_done = ((state_reg == WDR_ASYNC) && !lnk.filt_low)
                  || ((state_reg == WDR_SAMPLE) && (tmr_reg > SAMPLE_LAST) && !lnk.filt_low);
   assign wr_fire  = write_in && ack_reg;

   assign lnk.presc_sel = presc_reg;
   assign lnk.presc_clr = !counting || svc_fire;
   assign lnk.pin_raw_n = reset_in_pin_n_in;

   assign ctrl_val = {23'h00_0000, flags_reg, init_reg, enabled_reg, bidir_reg, presc_reg};

   // ==========================================================
   // register read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      if (address_in == `WDR_OFS_CTRL) begin
         rd_val = ctrl_val;
      end else if (address_in == `WDR_OFS_RELOAD) begin
         rd_val = {24'h00_0000, reload_reg};
      end else if (address_in == `WDR_OFS_COUNT) begin
         rd_val = 32'(count_reg);
      end else if (address_in == `WDR_OFS_IRQ_STAT) begin
         rd_val = {28'h000_0000, stat_reg};
      end else if (address_in == `WDR_OFS_IRQ_MASK) begin
         rd_val = {28'h000_0000, mask_reg};
      end
   end

   // ==========================================================
   // bus handshake: one wait cycle, then accept
   always_comb begin
      ack_next   = (read_in || write_in) && !ack_reg;
      rdata_next = rdata_reg;
      if (read_in && !ack_reg) begin
         rdata_next = rd_val;
      end
   end

   // ==========================================================
   // sequencer, watchdog counter and software-visible state
   always_comb begin
      state_next   = state_reg;
      src_next     = src_reg;
      tmr_next     = tmr_reg + 10'h001;
      count_next   = count_reg;
      reload_next  = reload_reg;
      presc_next   = presc_reg;
      bidir_next   = bidir_reg;
      enabled_next = enabled_reg;
      init_next    = init_reg;
      flags_next   = flags_reg;
      mask_next    = mask_reg;
      oe_next      = 1'b0;
      ev           = 4'h0;

      case (state_reg)
         WDR_IDLE: begin
            tmr_next = 10'h000;
            if (lnk.filt_low && mode_s2_reg) begin
               state_next = WDR_SYNC;
               src_next   = WDR_SRC_HW;
               flags_next = 5'h00;
               ev[`WDR_EV_HW] = 1'b1;
            end else if (lnk.filt_low) begin
               state_next = WDR_ASYNC;
               flags_next = 5'h00;
            end else if (software_reset_in) begin
               state_next = WDR_SYNC;
               src_next   = WDR_SRC_SW;
               flags_next = 5'h00;
               flags_next[`WDR_FLAG_SW] = 1'b1;
               ev[`WDR_EV_SW] = 1'b1;
            end else if (ovf_fire) begin
               state_next = WDR_SYNC;
               src_next   = WDR_SRC_WD;
               flags_next = 5'h00;
               flags_next[`WDR_FLAG_OVF] = 1'b1;
               ev[`WDR_EV_OVF] = 1'b1;
            end else begin
               if (svc_fire) begin
                  count_next = {reload_reg, 8'h00};
               end else if (counting && lnk.presc_tick) begin
                  count_next = count_reg + 1'b1;
               end
               if (disable_in && !init_reg) begin
                  enabled_next = 1'b0;
               end else if (disable_in) begin
                  ev[`WDR_EV_DIS_IGN] = 1'b1;
               end
               if (end_of_init_in) begin
                  init_next  = 1'b1;
                  flags_next = 5'h00;
               end
            end
            // the pin is only pulled when the mode pin allows it
            oe_next = (state_next == WDR_SYNC) && (src_next != WDR_SRC_HW)
                      && bidir_reg && mode_s2_reg;
         end
         WDR_ASYNC: begin
            tmr_next = 10'h000;
         end
         WDR_SYNC: begin
            oe_next = oe_reg;
            if (tmr_reg >= SYNC_LAST) begin
               state_next = WDR_SEQ;
               tmr_next   = 10'h000;
            end
         end
         WDR_SEQ: begin
            oe_next = oe_reg;
            if (tmr_reg >= SEQ_LAST) begin
               state_next = WDR_SAMPLE;
               tmr_next   = 10'h000;
               oe_next    = 1'b0;
            end
         end
         WDR_SAMPLE: begin
            // stays past the sample point while the pin is held low
            if (tmr_reg > SAMPLE_LAST) begin
               tmr_next = tmr_reg;
            end
            if ((tmr_reg == SAMPLE_LAST) && (src_reg == WDR_SRC_HW)) begin
               if (lnk.filt_low) begin
                  flags_next[`WDR_FLAG_LONG] = 1'b1;
               end else begin
                  flags_next[`WDR_FLAG_SHORT] = 1'b1;
               end
            end
         end
         default: begin
            state_next = WDR_IDLE;
         end
      endcase

      if (seq_done) begin
         state_next   = WDR_IDLE;
         src_next     = WDR_SRC_NONE;
         enabled_next = 1'b1;
         init_next    = 1'b0;
         count_next   = '0;
         bidir_next   = 1'b0;
      end

      // software writes; hardware events win over a one-to-clear
      stat_next = stat_reg;
      if (wr_fire && byteenable_in[0]) begin
         if (address_in == `WDR_OFS_CTRL) begin
            presc_next = writedata_in[`WDR_CTRL_PRESC];
            if (!seq_done) begin
               bidir_next = writedata_in[`WDR_CTRL_BIDIR];
            end
         end else if (address_in == `WDR_OFS_RELOAD) begin
            reload_next = writedata_in[7:0];
         end else if (address_in == `WDR_OFS_IRQ_STAT) begin
            stat_next = stat_reg & ~writedata_in[3:0];
         end else if (address_in == `WDR_OFS_IRQ_MASK) begin
            mask_next = writedata_in[3:0];
         end
      end
      stat_next = stat_next | ev;
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg   <= WDR_IDLE;
         src_reg     <= WDR_SRC_NONE;
         tmr_reg     <= 10'h000;
         count_reg   <= '0;
         reload_reg  <= 8'h00;
         presc_reg   <= 1'b0;
         bidir_reg   <= 1'b0;
         enabled_reg <= 1'b1;
         init_reg    <= 1'b0;
         flags_reg   <= `WDR_FLAGS_RESET;
         stat_reg    <= 4'h0;
         mask_reg    <= 4'h0;
         oe_reg      <= 1'b0;
         ack_reg     <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         src_reg     <= src_next;
         tmr_reg     <= tmr_next;
         count_reg   <= count_next;
         reload_reg  <= reload_next;
         presc_reg   <= presc_next;
         bidir_reg   <= bidir_next;
         enabled_reg <= enabled_next;
         init_reg    <= init_next;
         flags_reg   <= flags_next;
         stat_reg    <= stat_next;
         mask_reg    <= mask_next;
         oe_reg      <= oe_next;
         ack_reg     <= ack_next;
         rdata_reg   <= rdata_next;
         mode_s1_reg <= reset_mode_pin_in;
         mode_s2_reg <= mode_s1_reg;
      end
   end

   // ==========================================================
   // outputs
   assign waitrequest_out     = (read_in || write_in) && !ack_reg;
   assign readdata_out        = rdata_reg;
   assign chip_reset_out      = !state_reg[0];
   assign reset_out_pin_n_out = state_reg[0];
   assign reset_in_pin_out    = 1'b0;
   assign reset_in_pin_oe_out = oe_reg;
   assign irq_out             = |(stat_reg & mask_reg);

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   wd_restart_a: assert property (seq_done |=> enabled_reg && !init_reg)
      else $error("watchdog not re-enabled after reset sequence");
   disable_lock_a: assert property (idle && init_reg && enabled_reg && disable_in
      |=> enabled_reg)
      else $error("disable accepted after end of init");
   ovf_reset_a: assert property (ovf_fire && !lnk.filt_low && !software_reset_in
      |=> chip_reset_out [*8])
      else $error("overflow did not hold chip reset");
   reset_out_pin_low_a: assert property (src_reg == WDR_SRC_WD |-> !reset_out_pin_n_out)
      else $error("reset output pin high during overflow reset");
   ovf_flag_a: assert property (ovf_fire && !lnk.filt_low && !software_reset_in
      |=> flags_reg == 5'h08)
      else $error("overflow cause not recorded");
   end_of_init_instr_clear_a: assert property (idle && end_of_init_in && !lnk.filt_low
      && !software_reset_in && !ovf_fire |=> flags_reg == 5'h00)
      else $error("flags survive end of init");
   count_step_a: assert property (counting && lnk.presc_tick && !svc_fire && !ovf_fire
      && !lnk.filt_low && !software_reset_in |=> count_reg == $past(count_reg) + 1'b1)
      else $error("counter did not step on tick");
   service_load_a: assert property (svc_fire && !lnk.filt_low && !software_reset_in
      |=> count_reg == {$past(reload_reg), 8'h00})
      else $error("service did not load reload value");
   logic [9:0] seq_cyc_reg;
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         seq_cyc_reg <= 10'h000;
      end else begin
         seq_cyc_reg <= (state_reg == WDR_SEQ) ? seq_cyc_reg + 10'h001 : 10'h000;
      end
   end
   seq_length_a: assert property (state_reg == WDR_SEQ |=> state_reg
      == (($past(seq_cyc_reg) == SEQ_LAST) ? WDR_SAMPLE : WDR_SEQ))
      else $error("sequence length wrong");
   bidir_clear_a: assert property (seq_done |=> !bidir_reg)
      else $error("bidirectional enable not cleared");
   drive_gate_a: assert property (reset_in_pin_oe_out |-> src_reg != WDR_SRC_HW)
      else $error("pin driven during hardware reset");

   ovf_seen_c:   cover property (ovf_fire);
   long_seen_c:  cover property ($rose(flags_reg[`WDR_FLAG_LONG]));
   short_seen_c: cover property ($rose(flags_reg[`WDR_FLAG_SHORT]));
   drive_seen_c: cover property ($rose(reset_in_pin_oe_out));
endmodule

/* File: wdr_cpu_model.sv */
// cpu core model issuing the instruction strobes of the watchdog unit
`timescale 1ns/100ps
module wdr_cpu_model (
   input  wire logic clk_in,
   output logic      service_out,
   output logic      disable_out,
   output logic      end_of_init_out,
   output logic      software_reset_out
);
   // ==========================================================
   // strobes
   initial begin
      {service_out, disable_out, end_of_init_out, software_reset_out} = 4'h0;
   end

   // sel bits: service, disable, end of init, software reset
   task automatic issue(input logic [3:0] sel);
      @(posedge clk_in);
      {service_out, disable_out, end_of_init_out, software_reset_out} <= sel;
      @(posedge clk_in);
      {service_out, disable_out, end_of_init_out, software_reset_out} <= 4'h0;
   endtask
endmodule

/* File: watchdog_reset_source_unit_tb_top.sv */
// self-checking bench of the watchdog and reset source unit
`timescale 1ns/100ps
`include "wdr_cfg.svh"
module watchdog_reset_source_unit_tb_top import wdr_pkg::*;;
   logic        clk_in, reset_in, read_in, write_in, pin_drv_n, mode_pin;
   logic [4:0]  address_in;
   logic [31:0] writedata_in, readdata_out, rd;
   logic [3:0]  byteenable_in;
   logic        waitrequest_out, service, dis, eoi, sw_reset_flag;
   logic        pin_oe, pin_o, rst_out_n, chip_rst, irq_out;
   int          mismatches, tests_run, cycles, n, n_oe;
   // open-drain pin: low when either party pulls it
   wire logic   pin_wire_n = pin_drv_n & ~(pin_oe & ~pin_o);
   logic [4:0]  r_adr [6] = '{`WDR_OFS_RELOAD, `WDR_OFS_RELOAD, `WDR_OFS_IRQ_MASK,
                              `WDR_OFS_IRQ_MASK, `WDR_OFS_CTRL, 5'h14};
   logic [31:0] r_dat [6] = '{32'h0000_00A5, 32'h0000_01FF, 32'h0000_00FF,
                              32'h0000_0000, 32'h0000_01FF, 32'h0000_00FF};
   logic [31:0] r_exp [6] = '{32'h0000_00A5, 32'h0000_00FF, 32'h0000_000F,
                              32'h0000_0000, 32'h0000_0017, 32'h0000_0000};
   int          p_len [4] = '{5, 150, 800, 150};
   logic        p_mode[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic [31:0] p_exp [4] = '{32'h0000_000C, 32'h0000_0024, 32'h0000_0044, 32'h0000_0004};

   wdr_top dut (.clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
      .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
      .byteenable_in(byteenable_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .service_in(service), .disable_in(dis),
      .end_of_init_in(eoi), .software_reset_in(sw_reset_flag), .reset_in_pin_n_in(pin_wire_n),
      .reset_in_pin_out(pin_o), .reset_in_pin_oe_out(pin_oe),
      .reset_mode_pin_in(mode_pin), .reset_out_pin_n_out(rst_out_n),
      .chip_reset_out(chip_rst), .irq_out(irq_out));
   wdr_cpu_model cpu (.clk_in(clk_in), .service_out(service), .disable_out(dis),
      .end_of_init_out(eoi), .software_reset_out(sw_reset_flag));

   // ==========================================================
   // clock, timeout, helpers
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // request held until waitrequest is sampled low; read data taken at that edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {write_in, read_in, address_in, writedata_in} <= {wr, ~wr, a, d};
      do begin
         @(posedge clk_in);
      end while (waitrequest_out !== 1'b0);
      rd = readdata_out;
      {write_in, read_in} <= 2'h0;
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      check(rd, e);
   endtask

   // counts cycles until chip reset reaches lvl, and cycles with the pin pulled
   task automatic wait_cr(input logic lvl, input int lim);
      n = 0;
      n_oe = 0;
      while (chip_rst !== lvl && n < lim) begin
         @(posedge clk_in);
         n++;
         n_oe += (pin_oe === 1'b1);
      end
      check({31'h0000_0000, chip_rst === lvl}, 32'h0000_0001);
   endtask

   // one service, then tick count over a fixed gap of 256 clocks
   task automatic rate(input logic [31:0] ctl, input int lo, input int hi);
      logic [31:0] c0;
      bus(1'b1, `WDR_OFS_RELOAD, 32'h0000_00FF);
      bus(1'b1, `WDR_OFS_CTRL, ctl);
      cpu.issue(4'h8);
      bus(1'b0, `WDR_OFS_COUNT, 32'h0000_0000);
      c0 = rd;
      check({24'h00_0000, rd[15:8]}, 32'h0000_00FF);
      repeat (256) @(posedge clk_in);
      bus(1'b0, `WDR_OFS_COUNT, 32'h0000_0000);
      check({31'h0000_0000, (rd - c0) >= lo && (rd - c0) <= hi}, 32'h0000_0001);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {reset_in, read_in, write_in, pin_drv_n, mode_pin} = 5'h13;
      {address_in, writedata_in, byteenable_in} = {5'h00, 32'h0000_0000, 4'hF};
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      rdchk(`WDR_OFS_CTRL, 32'h0000_0014);
      check({31'h0000_0000, irq_out}, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, r_adr[i], r_dat[i]);
         rdchk(r_adr[i], r_exp[i]);
      end
      // a write without its low byte lane enabled leaves the register alone
      byteenable_in <= 4'hE;
      bus(1'b1, `WDR_OFS_RELOAD, 32'h0000_0011);
      byteenable_in <= 4'hF;
      rdchk(`WDR_OFS_RELOAD, 32'h0000_00FF);
      rate(32'h0000_0000, 127, 131);
      rate(32'h0000_0001, 1, 3);
      // overflow from reload ff at divide by two: 256 ticks of 2 clocks
      bus(1'b1, `WDR_OFS_CTRL, 32'h0000_0000);
      cpu.issue(4'h8);
      wait_cr(1'b1, 700);
      check({31'h0000_0000, n >= 505 && n <= 520}, 32'h0000_0001);
      check({31'h0000_0000, rst_out_n}, 32'h0000_0000);
      wait_cr(1'b0, 1000);
      check({31'h0000_0000, n >= 518 && n <= 528}, 32'h0000_0001);
      rdchk(`WDR_OFS_CTRL, 32'h0000_0084);
      cpu.issue(4'h4);
      rdchk(`WDR_OFS_CTRL, 32'h0000_0080);
      for (int m = 1; m >= 0; m--) begin
         mode_pin <= m[0];
         bus(1'b1, `WDR_OFS_CTRL, 32'h0000_0002);
         cpu.issue(4'h1);
         wait_cr(1'b1, 10);
         wait_cr(1'b0, 1000);
         check({31'h0000_0000, m ? (n_oe >= 510 && n_oe <= 525) : (n_oe == 0)},
               32'h0000_0001);
         rdchk(`WDR_OFS_CTRL, 32'h0000_0104);
      end
      // disable after end of init is refused and flagged as an interrupt
      bus(1'b1, `WDR_OFS_IRQ_STAT, 32'h0000_000F);
      bus(1'b1, `WDR_OFS_IRQ_MASK, 32'h0000_0008);
      cpu.issue(4'h2);
      rdchk(`WDR_OFS_CTRL, 32'h0000_000C);
      cpu.issue(4'h4);
      rdchk(`WDR_OFS_CTRL, 32'h0000_000C);
      rdchk(`WDR_OFS_IRQ_STAT, 32'h0000_0008);
      check({31'h0000_0000, irq_out}, 32'h0000_0001);
      bus(1'b1, `WDR_OFS_IRQ_MASK, 32'h0000_0000);
      @(posedge clk_in);
      check({31'h0000_0000, irq_out}, 32'h0000_0000);
      bus(1'b1, `WDR_OFS_IRQ_MASK, 32'h0000_0008);
      bus(1'b1, `WDR_OFS_IRQ_STAT, 32'h0000_0008);
      rdchk(`WDR_OFS_IRQ_STAT, 32'h0000_0000);
      check({31'h0000_0000, irq_out}, 32'h0000_0000);
      // pin pulses: spike, short, long, asynchronous; short one keeps 600 ns
      for (int i = 0; i < 4; i++) begin
         mode_pin <= p_mode[i];
         repeat (4) @(posedge clk_in);
         pin_drv_n <= 1'b0;
         repeat (p_len[i]) @(posedge clk_in);
         pin_drv_n <= 1'b1;
         repeat (20) @(posedge clk_in);
         wait_cr(1'b0, 2000);
         rdchk(`WDR_OFS_CTRL, p_exp[i]);
      end
      rdchk(`WDR_OFS_IRQ_STAT, 32'h0000_0004);
      reset_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      rdchk(`WDR_OFS_CTRL, 32'h0000_0014);
      print_verdict();
   end
endmodule
